// ---- hdl/lcm_control.sv ----
`timescale 1ns/1ns
// Operation
// - a read-addressed transfer shifts the system register out MSB first on master clocks
// - master ack at ninth clock starts another byte, no ack ends the read
// - writable bits read back exactly as written; only two flags are diagnostic
// - overtemp flag follows thermal shutdown, overload flag follows overload protection
// - below undervoltage lockout ignore the bus and hold the register at zero
// - interface accepts configuration only once supply is above the upper threshold
// - address pin level selects one of four addresses; ground gives 0001000
// - mode bit selects tone-burst (0) or control word (1) behaviour
// - in tone-burst mode the pin level gates the tone generator directly
// - tone-burst mode: voltage bit picks level, boost tracks output plus offset
// - control word mode: pin level selects low or high output voltage
// - control word mode: voltage bit only forces boost to fixed high target
// - control word mode, voltage bit clear: pin sets output and boost together
// - detector data appear on the open-drain detect output
// - register layout pulsed-limit..overload, bit7 to bit0, all zero at power-on
// - default address bytes 0x10 write, 0x11 read, lsb is direction
// - enable bit at zero disables all power blocks; cable comp and pulsed-limit outputs still follow their bits
module lcm_control (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // supply monitor (asserted while supply is above the upper lockout threshold)
    input  wire logic                 supply_ok,
    // serial bus, open drain data
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe,
    // address-select pin, quantised to one of four levels
    input  wire logic [1:0]           addr_level,
    // protection status from the analog side
    input  wire logic                 thermal_shutdown,
    input  wire logic                 overload_active,
    // tone and detect pins
    input  wire logic                 tone_or_level_pin,
    input  wire logic                 tone_detect_in,
    output logic                      tone_detect_out,
    output logic                      tone_detect_oe,
    // analog controls
    output logic                      power_enable,
    output logic                      tone_enable,
    output lcm_pkg::lcm_level_t       output_level,
    output logic                      cable_comp_boost,
    output lcm_pkg::lcm_boost_t       boost_target,
    output logic                      transmit_output,
    output logic                      receive_output,
    output logic                      pulsed_limit_select
);
    import lcm_pkg::*;

    lcm_sync_if sync ();

    lcm_pin_sampler u_sampler (
        .clk_sys           (clk_sys),
        .reset_n           (reset_n),
        .scl_in            (scl_in),
        .sda_in            (sda_in),
        .tone_or_level_pin (tone_or_level_pin),
        .tone_detect_in    (tone_detect_in),
        .sync              (sync.sampler)
    );

    lcm_state_t state_q;
    lcm_state_t state_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [3:0] count_q;
    logic [3:0] count_d;
    logic [5:0] ctrl_q;            // writable bits 7..2
    logic [5:0] ctrl_d;
    logic       rw_q;
    logic       rw_d;
    logic       sda_low_q;
    logic       sda_low_d;
    logic       ok_meta_q;
    logic       ok_q;
    logic [3:0] stat_meta_q;       // address level, overload, thermal
    logic [3:0] stat_q;

    // image of the register as read: writable bits plus live flags
    function automatic logic [7:0] sr_image(input logic [5:0] ctrl, input logic overtemp_flag, input logic overload_flag);
        logic [7:0] img;
        img                = SR_RESET;
        img[7:2]           = ctrl;
        img[BIT_OVERTEMP]  = overtemp_flag;
        img[BIT_OVERLOAD]  = overload_flag;
        return img;
    endfunction : sr_image

    // seven-bit address for the current pin level
    function automatic logic [6:0] own_address(input logic [1:0] lvl);
        return {ADDR_BASE, lvl};
    endfunction : own_address

    // supply monitor, analog status and address pin are asynchronous: two flops before use
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ok_meta_q   <= 1'b0;
            ok_q        <= 1'b0;
            stat_meta_q <= 4'h0;
            stat_q      <= 4'h0;
        end
        else
        begin
            ok_meta_q   <= supply_ok;
            ok_q        <= ok_meta_q;
            stat_meta_q <= {addr_level, overload_active, thermal_shutdown};
            stat_q      <= stat_meta_q;
        end
    end

    // bus slave; data changes on scl fall, sampled on scl rise
    always_comb
    begin
        state_d   = state_q;
        shift_d   = shift_q;
        count_d   = count_q;
        ctrl_d    = ctrl_q;
        rw_d      = rw_q;
        sda_low_d = sda_low_q;
        if (!ok_q)
        begin
            // lockout: no answer, register cleared
            state_d   = LCM_IDLE;
            ctrl_d    = SR_RESET[7:2];
            sda_low_d = 1'b0;
        end
        else if (sync.stop_seen)
        begin
            state_d   = LCM_IDLE;
            sda_low_d = 1'b0;
        end
        else if (sync.start_seen)
        begin
            state_d   = LCM_ADDR;
            count_d   = 4'h0;
            sda_low_d = 1'b0;
        end
        else if (sync.scl_rise)
        begin
            case (state_q)
                LCM_ADDR, LCM_WR_DATA:
                begin
                    shift_d = {shift_q[6:0], sync.sda_level};
                    count_d = count_q + 4'h1;
                end
                LCM_RD_ACK:
                begin
                    // high on ninth clock is no-ack: stop driving until next start
                    if (sync.sda_level)
                        state_d = LCM_IDLE;
                end
                default:
                begin
                end
            endcase
        end
        else if (sync.scl_fall)
        begin
            case (state_q)
                LCM_ADDR:
                begin
                    if (count_q == BIT_COUNT_ACK)
                    begin
                        if (shift_q[7:1] == own_address(stat_q[3:2]))
                        begin
                            state_d   = LCM_ADDR_ACK;
                            rw_d      = shift_q[0];
                            sda_low_d = 1'b1;
                        end
                        else
                            state_d = LCM_IDLE;
                    end
                end
                LCM_ADDR_ACK, LCM_WR_ACK, LCM_RD_ACK:
                begin
                    count_d = 4'h0;
                    if ((state_q == LCM_ADDR_ACK && rw_q) || state_q == LCM_RD_ACK)
                    begin
                        // flags resampled at the start of each byte
                        shift_d   = sr_image(ctrl_q, stat_q[0], stat_q[1]);
                        sda_low_d = ~shift_d[7];
                        state_d   = LCM_RD_DATA;
                    end
                    else
                    begin
                        sda_low_d = 1'b0;
                        state_d   = LCM_WR_DATA;
                    end
                end
                LCM_WR_DATA:
                begin
                    if (count_q == BIT_COUNT_ACK)
                    begin
                        ctrl_d    = shift_q[7:2]; // flags are read-only
                        sda_low_d = 1'b1;
                        state_d   = LCM_WR_ACK;
                    end
                end
                LCM_RD_DATA:
                begin
                    if (count_q == BIT_COUNT_LAST)
                    begin
                        sda_low_d = 1'b0;             // release for master ack
                        state_d   = LCM_RD_ACK;
                    end
                    else
                    begin
                        shift_d   = {shift_q[6:0], 1'b0};
                        count_d   = count_q + 4'h1;
                        sda_low_d = ~shift_d[7];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q   <= LCM_IDLE;
            shift_q   <= SR_RESET;
            count_q   <= 4'h0;
            ctrl_q    <= SR_RESET[7:2];
            rw_q      <= 1'b0;
            sda_low_q <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            shift_q   <= shift_d;
            count_q   <= count_d;
            ctrl_q    <= ctrl_d;
            rw_q      <= rw_d;
            sda_low_q <= sda_low_d;
        end
    end

    // analog control decode, registered so every output is a flop
    logic       en_d;
    logic       tone_d;
    lcm_level_t level_d;
    lcm_boost_t boost_d;
    logic       tx_d;
    logic       det_d;

    always_comb
    begin
        en_d    = ctrl_q[BIT_ENABLE - 2] & ~stat_q[0];
        level_d = LCM_LEVEL_LOW;
        boost_d = LCM_BOOST_OFF;
        tone_d  = 1'b0;
        if (!ctrl_q[BIT_COMM_MODE - 2])
        begin
            // tone-burst mode
            tone_d  = sync.tone_level;
            level_d = ctrl_q[BIT_VOLT_SEL - 2] ? LCM_LEVEL_HIGH : LCM_LEVEL_LOW;
            boost_d = ctrl_q[BIT_VOLT_SEL - 2] ? LCM_BOOST_HIGH : LCM_BOOST_LOW;
        end
        else
        begin
            level_d = sync.tone_level ? LCM_LEVEL_HIGH : LCM_LEVEL_LOW;
            if (ctrl_q[BIT_VOLT_SEL - 2])
                boost_d = LCM_BOOST_FORCED;
            else
                boost_d = sync.tone_level ? LCM_BOOST_HIGH : LCM_BOOST_LOW;
        end
        if (!en_d)
        begin
            tone_d  = 1'b0;
            boost_d = LCM_BOOST_OFF;
        end
        tx_d  = ctrl_q[BIT_TX_PATH - 2];
        // open drain: pull low while detector reports low
        det_d = ~sync.detect_level;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sda_out             <= 1'b0;
            sda_oe              <= 1'b0;
            tone_detect_out     <= 1'b0;
            tone_detect_oe      <= 1'b0;
            power_enable        <= 1'b0;
            tone_enable         <= 1'b0;
            output_level        <= LCM_LEVEL_LOW;
            cable_comp_boost    <= 1'b0;
            boost_target        <= LCM_BOOST_OFF;
            transmit_output     <= 1'b0;
            receive_output      <= 1'b0;
            pulsed_limit_select <= 1'b0;
        end
        else
        begin
            sda_out             <= 1'b0;
            sda_oe              <= sda_low_d;
            tone_detect_out     <= 1'b0;
            tone_detect_oe      <= det_d;
            power_enable        <= en_d;
            tone_enable         <= tone_d;
            output_level        <= level_d;
            cable_comp_boost    <= ctrl_q[BIT_CABLE_COMP - 2];
            boost_target        <= boost_d;
            transmit_output     <= en_d & tx_d;
            receive_output      <= en_d & ~tx_d;
            pulsed_limit_select <= ctrl_q[BIT_PULSED_LIMIT - 2];
        end
    end
endmodule : lcm_control

// ---- hdl/lcm_pin_sampler.sv ----
`timescale 1ns/1ns
// two-flop synchronisers for the bus, tone and detect pins plus bus edge and condition detection
module lcm_pin_sampler (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // raw pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic tone_or_level_pin,
    input  wire logic tone_detect_in,
    // synchronised view
    lcm_sync_if.sampler sync
);
    import lcm_pkg::*;

    logic [3:0] meta_q;
    logic [3:0] meta_d;
    logic [3:0] stab_q;
    logic [3:0] stab_d;
    logic [1:0] prev_q;
    logic [1:0] prev_d;

    // second flop is the only reader of the first
    always_comb
    begin
        meta_d = {tone_detect_in, tone_or_level_pin, sda_in, scl_in};
        stab_d = meta_q;
        prev_d = stab_q[1:0];
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= 4'hf;
            stab_q <= 4'hf;
            prev_q <= 2'h3;
        end
        else
        begin
            meta_q <= meta_d;
            stab_q <= stab_d;
            prev_q <= prev_d;
        end
    end

    // start/stop only count while clock is held high on both samples
    always_comb
    begin
        sync.scl_level    = stab_q[0];
        sync.sda_level    = stab_q[1];
        sync.tone_level   = stab_q[2];
        sync.detect_level = stab_q[3];
        sync.scl_rise     = stab_q[0] & ~prev_q[0];
        sync.scl_fall     = ~stab_q[0] & prev_q[0];
        sync.start_seen   = stab_q[0] & prev_q[0] & prev_q[1] & ~stab_q[1];
        sync.stop_seen    = stab_q[0] & prev_q[0] & ~prev_q[1] & stab_q[1];
    end
endmodule : lcm_pin_sampler

// ---- hdl/lcm_pkg.sv ----
package lcm_pkg;
    // system_control_status bit positions
    localparam int unsigned BIT_PULSED_LIMIT = 7;
    localparam int unsigned BIT_TX_PATH      = 6;
    localparam int unsigned BIT_COMM_MODE    = 5;
    localparam int unsigned BIT_CABLE_COMP   = 4;
    localparam int unsigned BIT_VOLT_SEL     = 3;
    localparam int unsigned BIT_ENABLE       = 2;
    localparam int unsigned BIT_OVERTEMP     = 1;
    localparam int unsigned BIT_OVERLOAD     = 0;
    localparam logic [7:0]  SR_RESET         = 8'h00;
    localparam logic [7:0]  SR_WRITE_MASK    = 8'hfc;

    // bus address: upper five bits fixed, low two from the address-select pin level
    localparam logic [4:0]  ADDR_BASE        = 5'h02;
    localparam logic [1:0]  ADDR_SEL_GND     = 2'h0;
    localparam logic [3:0]  BIT_COUNT_LAST   = 4'h7;
    localparam logic [3:0]  BIT_COUNT_ACK    = 4'h8;

    // output level codes (decoded by the analog side)
    typedef enum logic [1:0] {LCM_LEVEL_LOW, LCM_LEVEL_HIGH} lcm_level_t;
    // boost target codes
    typedef enum logic [2:0] {
        LCM_BOOST_OFF,
        LCM_BOOST_LOW,        // output low + offset
        LCM_BOOST_HIGH,       // output high + offset
        LCM_BOOST_FORCED      // fixed high target
    } lcm_boost_t;

    typedef enum logic [2:0] {
        LCM_IDLE,
        LCM_ADDR,
        LCM_ADDR_ACK,
        LCM_WR_DATA,
        LCM_WR_ACK,
        LCM_RD_DATA,
        LCM_RD_ACK
    } lcm_state_t;
endpackage : lcm_pkg

// ---- hdl/lcm_sync_if.sv ----
`timescale 1ns/1ns
// synchronised bus pin levels and detected edges, from the sampler to the control core
interface lcm_sync_if;
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic tone_level;
    logic detect_level;
    modport sampler (output scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen, tone_level,
                     detect_level);
    modport core    (input scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen, tone_level,
                     detect_level);
endinterface : lcm_sync_if

// ---- verif/lcm_control_properties.sv ----
`timescale 1ns/1ns
// pin-level checks; each ties an output to its cause at the inputs, to another output or to a fixed level
module lcm_control_properties (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // inputs of the block
    input wire logic supply_ok,
    input wire logic scl_in,
    input wire logic thermal_shutdown,
    input wire logic tone_or_level_pin,
    input wire logic tone_detect_in,
    // outputs of the block
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic tone_detect_out,
    input wire logic tone_detect_oe,
    input wire logic power_enable,
    input wire logic tone_enable,
    input wire logic transmit_output,
    input wire logic receive_output
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // pin paths pass two sync flops and an output flop, so a few quiet samples settle them
    sequence s_pin_low; !tone_or_level_pin [*4]; endsequence
    sequence s_det_low; !tone_detect_in [*4]; endsequence
    sequence s_det_high; tone_detect_in [*4]; endsequence
    sequence s_hot; thermal_shutdown [*4]; endsequence
    sequence s_no_supply; !supply_ok [*6]; endsequence
    property p_sda_data; sda_out == 1'b0; endproperty
    property p_sda_edge; $changed(sda_oe) |-> !$past(scl_in); endproperty
    property p_lockout; s_no_supply |-> !sda_oe; endproperty
    property p_tone_pin; s_pin_low |=> !tone_enable; endproperty
    property p_det_low; s_det_low |=> tone_detect_oe; endproperty
    property p_det_high; s_det_high |=> !tone_detect_oe; endproperty
    property p_det_data; tone_detect_out == 1'b0; endproperty
    property p_hot_off; s_hot |=> !power_enable; endproperty
    property p_one_path; !(transmit_output && receive_output); endproperty
    property p_power_path; power_enable |-> (transmit_output || receive_output); endproperty
    a_sda_data: assert property (p_sda_data) else $error("data driven high");
    a_sda_edge: assert property (p_sda_edge) else $error("data moved with clock high");
    a_lockout: assert property (p_lockout) else $error("ack in lockout");
    a_tone_pin: assert property (p_tone_pin) else $error("tone without pin");
    a_det_low: assert property (p_det_low) else $error("detect not pulled");
    a_det_high: assert property (p_det_high) else $error("detect stuck low");
    a_det_data: assert property (p_det_data) else $error("detect driven high");
    a_hot_off: assert property (p_hot_off) else $error("power on when hot");
    a_one_path: assert property (p_one_path) else $error("both paths on");
    a_power_path: assert property (p_power_path) else $error("power with no path");
endmodule : lcm_control_properties

bind lcm_control lcm_control_properties u_props (.*);

// ---- verif/lcm_host_model.sv ----
`timescale 1ns/1ns
// host controller: bus master that only pulls data low or lets it go
module lcm_host_model (
    // bench clock
    input  wire logic clk_sys,
    // bus wires
    input  wire logic sda,
    output logic      scl = 1'b1,
    output logic      sda_low = 1'b0
);
    // one clock pulse: data set mid-low, sampled late in the high phase for margin
    task automatic clk_bit(input logic b, output logic s);
        repeat (2) @(posedge clk_sys);
        #1 sda_low = !b;
        repeat (2) @(posedge clk_sys);
        #1 scl = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 s = sda;
        scl = 1'b0;
    endtask : clk_bit

    // start: data falls while the clock is high
    task automatic start_cond;
        repeat (2) @(posedge clk_sys);
        #1 sda_low = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 scl = 1'b0;
    endtask : start_cond

    // stop: data rises while the clock is high, then the bus idles
    task automatic stop_cond;
        repeat (2) @(posedge clk_sys);
        #1 sda_low = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 scl = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 sda_low = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : stop_cond

    // byte msb first, then the ninth clock; mack is the master's own ack on reads
    task automatic byte_x(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic sack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(d[i], s);
            q[i] = s;
        end
        clk_bit(!mack, s);
        sack = !s;
    endtask : byte_x
endmodule : lcm_host_model

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
// host model on the bus; a register image predicts every result
module tb;
    import lcm_pkg::*;
    // stimulus and observed pins
    logic       clk_sys = 1'b0, reset_n = 1'b0, supply_ok = 1'b1, scl, sda_low, ak;
    logic       thermal_shutdown = 1'b0, overload_active = 1'b0, tone_or_level_pin = 1'b0, tone_detect_in = 1'b1;
    logic [1:0] addr_level = 2'h0;
    logic       sda_out, sda_oe, tone_detect_out, tone_detect_oe, power_enable, tone_enable;
    logic       cable_comp_boost, transmit_output, receive_output, pulsed_limit_select;
    lcm_level_t output_level;
    lcm_boost_t boost_target;
    logic [7:0] d;
    logic [7:0] sr_model = 8'h00; // writable bits as last accepted
    int         errors = 0, samples_checked = 0, seed = 32'h3a85, k;
    // open-drain data with pull-up
    wire        sda = !sda_low && !(sda_oe && !sda_out);
    always #50 clk_sys = ~clk_sys;
    lcm_host_model host (.*);
    lcm_control dut (.*, .scl_in(scl), .sda_in(sda));

    task automatic complete_run;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // write; the data byte follows only an acked address
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] q;
        logic       x;
        host.start_cond();
        host.byte_x({a, 1'b0}, 1'b0, q, ak);
        if (ak)
            host.byte_x(v, 1'b0, q, x);
        host.stop_cond();
    endtask : wr

    // two-byte read; flags move during the first byte, so the second must show fresh ones
    task automatic rd2(input logic t2, input logic o2);
        logic [7:0] q1, q2, e1;
        logic       x;
        e1 = sr_model | {6'h00, thermal_shutdown, overload_active};
        host.start_cond();
        host.byte_x({5'h02, addr_level, 1'b1}, 1'b0, q1, ak);
        fork
            host.byte_x(8'hff, 1'b1, q1, x);
            begin
                repeat (20) @(posedge clk_sys);
                #1 thermal_shutdown = t2;
                overload_active = o2;
            end
        join
        host.byte_x(8'hff, 1'b0, q2, x);
        host.stop_cond();
        `CHK("read ack", 1'b1, ak)
        `CHK("read byte", e1, q1)
        `CHK("next byte", {sr_model[7:2], t2, o2}, q2)
        thermal_shutdown = 1'b0;
        overload_active = 1'b0;
    endtask : rd2

    // analog controls against the mode rules; thermal is clear here
    task automatic chk_out;
        logic       en;
        lcm_boost_t eb;
        en = sr_model[2];
        if (!en)
            eb = LCM_BOOST_OFF;
        else if (sr_model[5] && sr_model[3])
            eb = LCM_BOOST_FORCED;
        else
            eb = (sr_model[5] ? tone_or_level_pin : sr_model[3]) ? LCM_BOOST_HIGH : LCM_BOOST_LOW;
        `CHK("power", en, power_enable)
        `CHK("tone", en & !sr_model[5] & tone_or_level_pin, tone_enable)
        if (en)
            `CHK("level", lcm_level_t'(sr_model[5] ? tone_or_level_pin : sr_model[3]), output_level)
        `CHK("boost", eb, boost_target)
        `CHK("tx", en & sr_model[6], transmit_output)
        `CHK("rx", en & !sr_model[6], receive_output)
        `CHK("comp", sr_model[4], cable_comp_boost)
        `CHK("pcl", sr_model[7], pulsed_limit_select)
        `CHK("detect", !tone_detect_in, tone_detect_oe)
        `CHK("detect data", 1'b0, tone_detect_out)
    endtask : chk_out

    // hang guard
    initial
    begin
        repeat (99000) @(posedge clk_sys);
        errors++;
        complete_run();
    end

    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 rd2(1'b1, 1'b1);
        // each pin level answers its own address and refuses a neighbour
        for (k = 0; k < 4; k++)
        begin
            addr_level = 2'(k);
            wr({5'h02, 2'(k)}, 8'h00);
            `CHK("addr ack", 1'b1, ak)
            wr({5'h02, 2'(k ^ 1)}, 8'h00);
            `CHK("addr refuse", 1'b0, ak)
        end
        addr_level = 2'h0;
        // random configurations, checked at the outputs and read back
        for (k = 0; k < 14; k++)
        begin
            d = 8'($random(seed));
            wr(7'h08, d);
            `CHK("write ack", 1'b1, ak)
            sr_model = d & 8'hfc;
            tone_or_level_pin = 1'($random(seed));
            tone_detect_in = 1'($random(seed));
            repeat (5) @(posedge clk_sys);
            #1 chk_out();
            rd2(1'($random(seed)), 1'($random(seed)));
        end
        // control word: boost forced before the level pulses, voltage bit dropped once they end
        sr_model = 8'h2c;
        wr(7'h08, sr_model);
        repeat (20) @(posedge clk_sys);
        #1 chk_out();
        for (k = 0; k < 4; k++)
        begin
            tone_or_level_pin = k[0];
            repeat (5) @(posedge clk_sys);
            #1 chk_out();
        end
        sr_model = 8'h24;
        wr(7'h08, sr_model);
        chk_out();
        // undervoltage: no ack and the register drops to zero
        supply_ok = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 wr(7'h08, 8'hfc);
        `CHK("lockout ack", 1'b0, ak)
        sr_model = 8'h00;
        chk_out();
        supply_ok = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 wr(7'h08, 8'hd4);
        `CHK("ack after lockout", 1'b1, ak)
        sr_model = 8'hd4;
        rd2(1'b0, 1'b1);
        complete_run();
    end
endmodule : tb
